// *** design/ccr_pkg.sv ***
// Package with offsets, field layouts, reset values and timing for control registers two and three
package ccr_pkg;
  localparam logic [7:0] CONV_DETECT_CTRL_OFS     = 8'h02;
  localparam logic [7:0] CHARGE_IND_CTRL_OFS      = 8'h03;
  localparam logic [7:0] CONV_DETECT_CTRL_RST     = 8'h1d;
  localparam logic [7:0] CHARGE_IND_CTRL_RST      = 8'h1a;
  localparam int         CLK_PERIOD_NS            = 10;
  localparam int         MEAS_REPEAT_PERIOD_MS    = 1000;
  localparam int         MEAS_REPEAT_CYCLES       = MEAS_REPEAT_PERIOD_MS * (1000000 / CLK_PERIOD_NS);
  // Field positions, first register
  localparam int         GO_BIT                   = 7;
  localparam int         RATE_BIT                 = 6;
  localparam int         BFREQ_BIT                = 5;
  localparam int         ICO_BIT                  = 4;
  localparam int         HVP_BIT                  = 3;
  localparam int         ADJ_BIT                  = 2;
  localparam int         FORCE_DET_BIT            = 1;
  localparam int         AUTO_DET_BIT             = 0;
  // Field positions, second register
  localparam int         IND_CTRL_BIT             = 7;
  localparam int         KICK_BIT                 = 6;
  localparam int         BOOST_EN_BIT             = 5;
  localparam int         CHG_EN_BIT               = 4;
  localparam int         FLOOR_LSB                = 1;
  localparam int         BATLOW_BIT               = 0;

  typedef struct packed {
    logic       meas_conversion_go;
    logic       meas_repeat_select;
    logic       boost_switch_rate_sel;
    logic       input_current_optimizer_on;
    logic       high_volt_port_handshake_on;
    logic       adjustable_adapter_handshake_on;
    logic       forced_source_detection;
    logic       plugin_source_detection_on;
  } ccr_conv_detect_s;

  typedef struct packed {
    logic       indicator_ctrl;
    logic       watchdog_kick;
    logic       boost_output_enable;
    logic       charging_enable;
    logic [2:0] system_voltage_floor;
    logic       bat_low_select;
  } ccr_charge_ind_s;
endpackage

// *** design/ccr_ctrl_regs.sv ***
// Conversion/detection and charge/indicator control registers with their side effects
// Summary of operation
// - Writing one to go launches a conversion; reads one during conversion or detection.
// - While repeat mode is on, writes to the go bit are ignored.
// - Repeat bit zero gives one-shot, one gives a conversion every second.
// - Boost rate bit picks 1.5MHz or 500KHz; ignored while boost output is enabled.
// - Bit 4 enables the input current optimizer; resets to one.
// - Bits 3 and 2 enable high-voltage and adjustable handshakes; both reset one.
// - Writing one to forced detection starts detection; reads zero when idle.
// - Plug-in detection runs on VBUS plug-in only while its enable bit is one.
// - Watchdog kick restarts the timer and clears itself once the timer is reset.
// - Adapter present: one if plugged, follows control bit in boost, else zero.
// - Plugged adapter with detection or fast adapter drives line select to one.
// - Other sources and boost: line select equals control bit; battery only gives zero.
// - Bits 3..1 set system floor 3.0V plus 0.1V per count; reset 101.
// - Bit 0 selects battery low threshold 2.9V or 2.5V; reset zero.
// - On watchdog expiry the watchdog-resettable fields return to defaults.
`timescale 1ns/1ps
module ccr_ctrl_regs #(
  parameter int REPEAT_CYCLES = ccr_pkg::MEAS_REPEAT_CYCLES
) (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [7:0]             i_reg_addr,
  input  wire logic [7:0]             i_reg_wdata,
  output logic                        o_reg_addr_ok,
  output logic      [7:0]             o_reg_rdata,
  input  wire logic                   i_conv_busy,
  input  wire logic                   i_conv_done,
  input  wire logic                   i_detect_busy,
  input  wire logic                   i_detect_done,
  input  wire logic                   i_vbus_plugin,
  input  wire logic                   i_adapter_plugged,
  input  wire logic                   i_fast_adapter,
  input  wire logic                   i_wd_reset_done,
  input  wire logic                   i_wd_expired,
  output logic                        o_meas_conversion_go,
  output logic                        o_detect_start,
  output logic                        o_adapter_present_out,
  output logic                        o_line_select_out,
  output ccr_pkg::ccr_conv_detect_s   o_conv_detect,
  output ccr_pkg::ccr_charge_ind_s    o_charge_ind
);
  // Refused at elaboration, so a bad count never reaches a netlist
  if (REPEAT_CYCLES < 2)
  begin
    $error("REPEAT_CYCLES must be at least 2");
  end

  ccr_pkg::ccr_conv_detect_s  cd_r, cd_nxt;
  ccr_pkg::ccr_charge_ind_s   ci_r, ci_nxt;
  logic [31:0]                rep_cnt_r, rep_cnt_nxt;
  logic [7:0]                 rdata_r, rdata_nxt;
  logic                       cstart_r, cstart_nxt;
  logic                       dstart_r, dstart_nxt;
  logic                       conv_fin_r, conv_fin_nxt;
  logic                       wr_cd, wr_ci, rep_tick;

  assign wr_cd    = i_reg_wr && (i_reg_addr == ccr_pkg::CONV_DETECT_CTRL_OFS);
  assign wr_ci    = i_reg_wr && (i_reg_addr == ccr_pkg::CHARGE_IND_CTRL_OFS);
  assign rep_tick = cd_r.meas_repeat_select && (rep_cnt_r == 32'(REPEAT_CYCLES - 1));
  assign o_reg_addr_ok = (i_reg_addr == ccr_pkg::CONV_DETECT_CTRL_OFS)
                      || (i_reg_addr == ccr_pkg::CHARGE_IND_CTRL_OFS);

  always_comb
  begin
    cd_nxt      = cd_r;
    ci_nxt      = ci_r;
    cstart_nxt  = 1'b0;
    dstart_nxt  = 1'b0;
    rep_cnt_nxt = cd_r.meas_repeat_select && !rep_tick ? rep_cnt_r + 32'h1 : 32'h0;
    conv_fin_nxt = conv_fin_r;
    // Completion clears first so a same-cycle write still sets
    if (i_conv_done && cd_r.meas_conversion_go)
      conv_fin_nxt = 1'b1;
    // Conversion may end before detection, so remember it until detection is idle
    if ((i_conv_done || conv_fin_r) && !i_detect_busy)
    begin
      cd_nxt.meas_conversion_go = 1'b0;
      conv_fin_nxt = 1'b0;
    end
    if (i_detect_done)
      cd_nxt.forced_source_detection = 1'b0;
    if (i_wd_reset_done)
      ci_nxt.watchdog_kick = 1'b0;
    if (wr_cd)
    begin
      if (i_reg_wdata[ccr_pkg::GO_BIT] && !cd_r.meas_repeat_select)
      begin
        cd_nxt.meas_conversion_go = 1'b1;
        conv_fin_nxt = 1'b0;
        cstart_nxt = 1'b1;
      end
      cd_nxt.meas_repeat_select = i_reg_wdata[ccr_pkg::RATE_BIT];
      if (!ci_r.boost_output_enable)
        cd_nxt.boost_switch_rate_sel = i_reg_wdata[ccr_pkg::BFREQ_BIT];
      cd_nxt.input_current_optimizer_on      = i_reg_wdata[ccr_pkg::ICO_BIT];
      cd_nxt.high_volt_port_handshake_on     = i_reg_wdata[ccr_pkg::HVP_BIT];
      cd_nxt.adjustable_adapter_handshake_on = i_reg_wdata[ccr_pkg::ADJ_BIT];
      if (i_reg_wdata[ccr_pkg::FORCE_DET_BIT])
      begin
        cd_nxt.forced_source_detection = 1'b1;
        dstart_nxt = 1'b1;
      end
      cd_nxt.plugin_source_detection_on = i_reg_wdata[ccr_pkg::AUTO_DET_BIT];
    end
    if (rep_tick)
      cstart_nxt = 1'b1;
    if (i_vbus_plugin && cd_r.plugin_source_detection_on)
      dstart_nxt = 1'b1;
    if (wr_ci)
    begin
      ci_nxt.indicator_ctrl       = i_reg_wdata[ccr_pkg::IND_CTRL_BIT];
      if (i_reg_wdata[ccr_pkg::KICK_BIT])
        ci_nxt.watchdog_kick      = 1'b1;
      ci_nxt.boost_output_enable  = i_reg_wdata[ccr_pkg::BOOST_EN_BIT];
      ci_nxt.charging_enable      = i_reg_wdata[ccr_pkg::CHG_EN_BIT];
      ci_nxt.system_voltage_floor = i_reg_wdata[ccr_pkg::FLOOR_LSB +: 3];
      ci_nxt.bat_low_select       = i_reg_wdata[ccr_pkg::BATLOW_BIT];
    end
    // Expiry overrides host writes except the detection start pulse; software-only fields keep their value
    if (i_wd_expired)
    begin
      cd_nxt.meas_conversion_go      = ccr_pkg::CONV_DETECT_CTRL_RST[ccr_pkg::GO_BIT];
      cd_nxt.meas_repeat_select      = ccr_pkg::CONV_DETECT_CTRL_RST[ccr_pkg::RATE_BIT];
      cd_nxt.boost_switch_rate_sel   = ccr_pkg::CONV_DETECT_CTRL_RST[ccr_pkg::BFREQ_BIT];
      cd_nxt.forced_source_detection = ccr_pkg::CONV_DETECT_CTRL_RST[ccr_pkg::FORCE_DET_BIT];
      ci_nxt.watchdog_kick           = ccr_pkg::CHARGE_IND_CTRL_RST[ccr_pkg::KICK_BIT];
      ci_nxt.boost_output_enable     = ccr_pkg::CHARGE_IND_CTRL_RST[ccr_pkg::BOOST_EN_BIT];
      ci_nxt.charging_enable         = ccr_pkg::CHARGE_IND_CTRL_RST[ccr_pkg::CHG_EN_BIT];
      cstart_nxt                     = 1'b0;
      conv_fin_nxt                   = 1'b0;
      rep_cnt_nxt                    = 32'h0;
    end
    rdata_nxt = rdata_r;
    if (i_reg_rd)
    begin
      if (i_reg_addr == ccr_pkg::CONV_DETECT_CTRL_OFS)
      begin
        rdata_nxt = cd_r;
        rdata_nxt[ccr_pkg::GO_BIT] = cd_r.meas_conversion_go || i_conv_busy || i_detect_busy;
      end
      else if (i_reg_addr == ccr_pkg::CHARGE_IND_CTRL_OFS)
        rdata_nxt = ci_r;
      else
        rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      cd_r      <= ccr_pkg::CONV_DETECT_CTRL_RST;
      ci_r      <= ccr_pkg::CHARGE_IND_CTRL_RST;
      rep_cnt_r <= 32'h0;
      rdata_r   <= 8'h00;
      cstart_r  <= 1'b0;
      dstart_r  <= 1'b0;
      conv_fin_r <= 1'b0;
    end
    else
    begin
      cd_r      <= cd_nxt;
      ci_r      <= ci_nxt;
      rep_cnt_r <= rep_cnt_nxt;
      rdata_r   <= rdata_nxt;
      cstart_r  <= cstart_nxt;
      dstart_r  <= dstart_nxt;
      conv_fin_r <= conv_fin_nxt;
    end
  end

  // Indicators are combinational so they track plug events without a cycle lag
  always_comb
  begin
    if (i_adapter_plugged)
    begin
      o_adapter_present_out = 1'b1;
      o_line_select_out = i_detect_busy || cd_r.forced_source_detection || i_fast_adapter
                          || ci_r.indicator_ctrl;
    end
    else if (ci_r.boost_output_enable)
    begin
      o_adapter_present_out = ci_r.indicator_ctrl;
      o_line_select_out     = ci_r.indicator_ctrl;
    end
    else
    begin
      o_adapter_present_out = 1'b0;
      o_line_select_out     = 1'b0;
    end
  end

  assign o_reg_rdata    = rdata_r;
  assign o_meas_conversion_go   = cstart_r;
  assign o_detect_start = dstart_r;
  assign o_conv_detect  = cd_r;
  assign o_charge_ind   = ci_r;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  sequence s_go_write;
    wr_cd && i_reg_wdata[ccr_pkg::GO_BIT] && !cd_r.meas_repeat_select && !i_wd_expired;
  endsequence

  AST_GO_LAUNCH: assert property (s_go_write |=> o_meas_conversion_go && cd_r.meas_conversion_go)
    else $error("go write did not launch a conversion");
  AST_GO_CLEAR: assert property (conv_fin_r && !i_detect_busy && !wr_cd
                                 |=> !cd_r.meas_conversion_go)
    else $error("go stayed set after conversion and detection ended");
  AST_GO_READONLY: assert property (wr_cd && cd_r.meas_repeat_select && !rep_tick
                                    |=> !o_meas_conversion_go)
    else $error("go write took effect in repeat mode");
  AST_REPEAT_TICK: assert property (rep_tick && !i_wd_expired |=> o_meas_conversion_go)
    else $error("repeat period did not start a conversion");
  AST_BFREQ_LOCK: assert property (ci_r.boost_output_enable && !i_wd_expired
                                   |=> $stable(cd_r.boost_switch_rate_sel))
    else $error("boost rate changed while boost enabled");
  AST_DETECT_PLUGIN: assert property (i_vbus_plugin && !cd_r.plugin_source_detection_on
                                      && !wr_cd |=> !o_detect_start)
    else $error("plug-in detection ran while disabled");
  AST_KICK_CLEAR: assert property (i_wd_reset_done && !(wr_ci && i_reg_wdata[ccr_pkg::KICK_BIT])
                                   |=> !ci_r.watchdog_kick)
    else $error("kick did not clear after timer reset");
  AST_ADAPTER_OUT: assert property (!i_adapter_plugged && !ci_r.boost_output_enable
                                    |-> !o_adapter_present_out && !o_line_select_out)
    else $error("indicators high with battery only");
  AST_LINE_SEL: assert property (i_adapter_plugged && i_fast_adapter |-> o_line_select_out)
    else $error("line select low for fast adapter");
  AST_FLOOR_WRITE: assert property (wr_ci && !i_wd_expired
                                    |=> o_charge_ind.system_voltage_floor
                                        == $past(i_reg_wdata[3:1]))
    else $error("system floor not updated by write");
  AST_WD_EXPIRE: assert property (i_wd_expired |=> !cd_r.meas_repeat_select
                                  && ci_r.charging_enable && !ci_r.boost_output_enable)
    else $error("fields not restored on watchdog expiry");
endmodule

// *** sim/ccr_host.sv ***
// Host-side model of the register byte port feeding the control registers
`timescale 1ns/1ps
module ccr_host (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'hff;
    o_wdata = 8'hff;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
    // Inverted so a stale byte is never mistaken for data
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
endmodule

// *** sim/test_charger_control_regs_two_three.sv ***
// Self-checking testbench for the two charger control registers
`timescale 1ns/1ps
module test_charger_control_regs_two_three;
  localparam int RC = 20;
  logic       clk, rst_b, wr, rd, cb, db, ap, fa, cs, ds, pres, lsel, aok;
  logic [4:0] pv;
  logic [7:0] addr, wdata, rdata, rv;
  ccr_pkg::ccr_conv_detect_s cdr;
  ccr_pkg::ccr_charge_ind_s  ci;
  int         n_mismatch = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         n;
  ccr_ctrl_regs #(.REPEAT_CYCLES(RC)) ccr_ctrl_regs_i (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_addr_ok(aok), .o_reg_rdata(rdata), .i_conv_busy(cb),
    .i_conv_done(pv[0]), .i_detect_busy(db), .i_detect_done(pv[1]), .i_vbus_plugin(pv[2]),
    .i_adapter_plugged(ap), .i_fast_adapter(fa), .i_wd_reset_done(pv[3]),
    .i_wd_expired(pv[4]), .o_meas_conversion_go(cs), .o_detect_start(ds),
    .o_adapter_present_out(pres), .o_line_select_out(lsel), .o_conv_detect(cdr),
    .o_charge_ind(ci));
  ccr_host ccr_host_i (.i_clk_sys(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdata));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop;
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    pv[i] <= 1'b1;
    @(posedge clk);
    pv[i] <= 1'b0;
    #1;
  endtask
  // Any fixed phase of the repeat counter gives two pulses in two periods
  task automatic cnt;
    n = 0;
    repeat (2 * RC)
    begin
      @(posedge clk);
      #1;
      if (cs === 1'b1) n++;
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    ccr_host_i.wr_reg(a, d);
  endtask
  task automatic t_reset;
    ccr_host_i.rd_reg(8'h02, rv);
    chk("reg2", ccr_pkg::CONV_DETECT_CTRL_RST, rv);
    fork
      ccr_host_i.rd_reg(8'h03, rv);
      begin
        @(posedge clk);
        #1;
        chkb("addr_ok", 1'b1, aok);
      end
    join
    chk("reg3", 8'h1a, rv);
    w(8'h04, 8'hff);
    ccr_host_i.rd_reg(8'h04, rv);
    chk("unmapped", 8'h00, rv);
    chkb("addr_ok", 1'b0, aok);
    chk("reg2f", 8'h1d, cdr);
    w(8'h03, 8'h1e);
    chk("floor", 8'h1e, ci);
    w(8'h03, 8'h1a);
  endtask
  task automatic t_go;
    w(8'h02, 8'h9d);
    chkb("meas_conversion_go", 1'b1, cs);
    @(posedge clk);
    cb <= 1'b1;
    db <= 1'b1;
    pulse(0);
    chkb("go", 1'b1, cdr.meas_conversion_go);
    @(posedge clk);
    cb <= 1'b0;
    db <= 1'b0;
    pulse(0);
    chk("reg2f", 8'h1d, cdr);
    @(posedge clk);
    db <= 1'b1;
    ccr_host_i.rd_reg(8'h02, rv);
    chk("reg2", 8'h9d, rv);
    db <= 1'b0;
  endtask
  task automatic t_repeat;
    w(8'h02, 8'h5d);
    cnt();
    chk("pulses", 8'h02, 8'(n));
    w(8'h02, 8'hdd);
    chk("reg2f", 8'h5d, cdr);
    w(8'h02, 8'h1d);
    cnt();
    chk("pulses", 8'h00, 8'(n));
  endtask
  task automatic t_boost;
    w(8'h03, 8'h3a);
    w(8'h02, 8'h3d);
    chk("reg2f", 8'h1d, cdr);
    w(8'h03, 8'h1a);
    w(8'h02, 8'h3d);
    chk("reg2f", 8'h3d, cdr);
    w(8'h02, 8'h1d);
  endtask
  task automatic ind(input logic [2:0] c, input logic [7:0] r3, input logic [1:0] e);
    @(posedge clk);
    {ap, fa, db} <= c;
    w(8'h03, r3);
    chkb("present", e[1], pres);
    chkb("line_sel", e[0], lsel);
  endtask
  task automatic t_ind;
    ind(3'h4, 8'h1a, 2'h2);
    ind(3'h6, 8'h1a, 2'h3);
    ind(3'h5, 8'h1a, 2'h3);
    ind(3'h4, 8'h9a, 2'h3);
    ind(3'h0, 8'hba, 2'h3);
    ind(3'h0, 8'h3a, 2'h0);
    ind(3'h0, 8'h9a, 2'h0);
    w(8'h03, 8'h1a);
  endtask
  task automatic t_detect;
    w(8'h02, 8'h1f);
    chkb("det_start", 1'b1, ds);
    pulse(1);
    chk("reg2f", 8'h1d, cdr);
    pulse(2);
    chkb("det_start", 1'b1, ds);
    w(8'h02, 8'h1c);
    pulse(2);
    chkb("det_start", 1'b0, ds);
    w(8'h02, 8'h1d);
  endtask
  task automatic t_wd;
    w(8'h03, 8'h5a);
    chk("reg3f", 8'h5a, ci);
    pulse(3);
    chk("reg3f", 8'h1a, ci);
    w(8'h02, 8'h60);
    w(8'h03, 8'h7b);
    ccr_host_i.rd_reg(8'h03, rv);
    chk("reg3", 8'h7b, rv);
    pulse(4);
    chk("reg2f", 8'h00, cdr);
    chk("reg3f", 8'h1b, ci);
  endtask
  initial
  begin
    {cb, db, ap, fa} = 4'h0;
    pv = 5'h00;
    rst_b = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_go();
    t_repeat();
    t_boost();
    t_ind();
    t_detect();
    t_wd();
    report_and_stop();
  end
endmodule
